// *** uambs_defines.svh ***
`ifndef UAMBS_DEFINES_SVH
`define UAMBS_DEFINES_SVH

// register byte offsets on the apb
`define UAMBS_OFF_CTRL      12'h000
`define UAMBS_OFF_ADDR      12'h004
`define UAMBS_OFF_MASK      12'h008
`define UAMBS_OFF_STAT      12'h00c
`define UAMBS_OFF_IRQ_MASK  12'h010
`define UAMBS_OFF_T1_RELOAD 12'h014
`define UAMBS_OFF_T2_RELOAD 12'h018
`define UAMBS_OFF_RX_DATA   12'h01c
`define UAMBS_OFF_IER       12'h020

// control register fields
`define UAMBS_CTRL_MODE_LSB  0
`define UAMBS_CTRL_MP_BIT    2
`define UAMBS_CTRL_DBL_BIT   3
`define UAMBS_CTRL_T2RX_BIT  4
`define UAMBS_CTRL_T2TX_BIT  5
`define UAMBS_CTRL_T1RUN_BIT 6
`define UAMBS_CTRL_T2RUN_BIT 7

// status bits
`define UAMBS_ST_RX_DONE 0
`define UAMBS_ST_DROP    1
`define UAMBS_ST_W       2

// reset values
`define UAMBS_RST_ADDR 8'h00
`define UAMBS_RST_MASK 8'h00
`define UAMBS_RST_CTRL 8'h00

// divider counts
`define UAMBS_DIV_SHIFT 12
`define UAMBS_DIV_FIX   64
`define UAMBS_DIV_T1    32
`define UAMBS_DIV_T1PRE 12
`define UAMBS_DIV_T2    16
`define UAMBS_DIV_T2PRE 2

`endif

// *** uambs_pkg.sv ***
`default_nettype none
package uambs_pkg;
   typedef enum logic [1:0] {
      UAMBS_MODE_SHIFT = 2'b00,
      UAMBS_MODE_VAR8  = 2'b01,
      UAMBS_MODE_FIX9  = 2'b10,
      UAMBS_MODE_VAR9  = 2'b11
   } uambs_mode_t;
endpackage
`default_nettype wire

// *** uambs_match_if.sv ***
`default_nettype none
interface uambs_match_if;
   logic [7:0] own_address;
   logic [7:0] address_mask;
   logic [7:0] rx_byte;
   logic       hit;
   modport host (output own_address, output address_mask, output rx_byte, input hit);
   modport cmp  (input own_address, input address_mask, input rx_byte, output hit);
endinterface
`default_nettype wire

// *** uambs_addr_cmp.sv ***
`default_nettype none
module uambs_addr_cmp (
   uambs_match_if.cmp m
);
   logic [7:0] given_ok;
   logic [7:0] bcast_ok;
   logic [7:0] bcast;

   assign bcast = m.own_address | m.address_mask;

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         assign given_ok[i] = ~m.address_mask[i] | (m.rx_byte[i] == m.own_address[i]);
         assign bcast_ok[i] = ~bcast[i] | m.rx_byte[i];
      end
   endgenerate

   assign m.hit = (&given_ok) | (&bcast_ok);
endmodule
`default_nettype wire

// *** uambs_tick_div.sv ***
`default_nettype none
// divides a tick stream by a count; doubler halves the count
module uambs_tick_div #(
   parameter int DIV = 16
) (
   input  wire logic sys_clk_in,
   input  wire logic rst_b_in,
   input  wire logic tick_in,
   input  wire logic halve_in,
   input  wire logic clear_in,
   output logic      tick_out
);
   localparam int W = $clog2(DIV);

   if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
      $error("uambs_tick_div: DIV must be even and >= 2");
   end

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         pulse;
   } uambs_div_t;

   uambs_div_t s_q;
   uambs_div_t s_d;
   logic [W-1:0] last;

   assign last = halve_in ? W'(DIV / 2 - 1) : W'(DIV - 1);

   always_comb begin
      s_d = s_q;
      s_d.pulse = 1'b0;
      if (clear_in) begin
         s_d.cnt = '0;
      end else if (tick_in) begin
         if (s_q.cnt >= last) begin
            s_d.cnt = '0;
            s_d.pulse = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_out = s_q.pulse;
endmodule
`default_nettype wire

// *** uambs_top.sv ***
`include "uambs_defines.svh"
`default_nettype none
// Overview of operation
// - multiproc mode: done only on address match
// - nine-bit modes drop ninth-bit-zero frames when multiproc enable is set
// - ten-bit mode: stop bit marks address
// - shift mode ignores multiproc enable
// - given address: masked bits must equal
// - broadcast is own OR mask
// - address and mask reset to zero
// - interrupt needs serial interrupt enable
// - transmit and receive clocks run independently in variable modes
// - shift mode rate is osc/12
// - fixed nine-bit rate osc/64, doubler doubles
// - variable modes: timer1 default, timer2 selectable
// - timer1 rate: overflow/32, doubler doubles
// - timer1 auto-reload byte sets rate
// - timer2 reloads 16 bits on rollover
// - timer2 rate: overflow/16, no doubler
module uambs_top (
   input  wire logic        sys_clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        frame_valid_in,
   input  wire logic [7:0]  frame_data_in,
   input  wire logic        frame_bit9_in,
   input  wire logic        frame_stop_ok_in,
   output logic             rx_baud_tick_out,
   output logic             tx_baud_tick_out,
   output logic             irq_out
);
   // frame inputs come from the receive shifter on this clock: no synchroniser
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  own_address;
      logic [7:0]  address_mask;
      logic [1:0]  stat;
      logic [1:0]  irq_mask;
      logic        serial_irq_enable;
      logic [7:0]  timer_one_reload_byte;
      logic [15:0] t2_reload;
      logic [7:0]  t1_count;
      logic [3:0]  t1_pre;
      logic [15:0] t2_count;
      logic        t2_pre;
      logic [3:0]  sh_pre;
      logic        t1_ovf;
      logic        t2_ovf;
      logic        sh_tick;
      logic [7:0]  rx_data;
      logic [31:0] rdata;
   } uambs_state_t;

   uambs_state_t s_q;
   uambs_state_t s_d;

   uambs_match_if mif ();
   uambs_addr_cmp u_cmp (.m(mif));

   uambs_pkg::uambs_mode_t mode;
   logic multiproc_enable;
   logic baud_doubler;
   logic t2_rx_sel;
   logic t2_tx_sel;
   logic fix_tick;
   logic t1_div_tick;
   logic t2_div_rx;
   logic t2_div_tx;
   logic t1_div_tx;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic accept;
   logic drop;

   assign mode              = uambs_pkg::uambs_mode_t'(s_q.ctrl[`UAMBS_CTRL_MODE_LSB +: 2]);
   assign multiproc_enable  = s_q.ctrl[`UAMBS_CTRL_MP_BIT];
   assign baud_doubler      = s_q.ctrl[`UAMBS_CTRL_DBL_BIT];
   assign t2_rx_sel         = s_q.ctrl[`UAMBS_CTRL_T2RX_BIT];
   assign t2_tx_sel         = s_q.ctrl[`UAMBS_CTRL_T2TX_BIT];

   assign mif.own_address   = s_q.own_address;
   assign mif.address_mask  = s_q.address_mask;
   assign mif.rx_byte       = frame_data_in;

   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && !penable && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // only exact word offsets decode; anything else answers with an error
   always_comb begin
      if (paddr == `UAMBS_OFF_CTRL) begin
         addr_ok = 1'b1;
      end else if (paddr == `UAMBS_OFF_ADDR) begin
         addr_ok = 1'b1;
      end else if (paddr == `UAMBS_OFF_MASK) begin
         addr_ok = 1'b1;
      end else if (paddr == `UAMBS_OFF_STAT) begin
         addr_ok = 1'b1;
      end else if (paddr == `UAMBS_OFF_IRQ_MASK) begin
         addr_ok = 1'b1;
      end else if (paddr == `UAMBS_OFF_T1_RELOAD) begin
         addr_ok = 1'b1;
      end else if (paddr == `UAMBS_OFF_T2_RELOAD) begin
         addr_ok = 1'b1;
      end else if (paddr == `UAMBS_OFF_RX_DATA) begin
         addr_ok = 1'b1;
      end else if (paddr == `UAMBS_OFF_IER) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   end
   assign prdata  = s_q.rdata;

   // frame acceptance decision
   always_comb begin
      accept = 1'b0;
      drop   = 1'b0;
      if (frame_valid_in) begin
         case (mode)
            uambs_pkg::UAMBS_MODE_SHIFT: begin
               accept = 1'b1;
            end
            uambs_pkg::UAMBS_MODE_VAR8: begin
               accept = !multiproc_enable || (frame_stop_ok_in && mif.hit);
            end
            default: begin
               accept = !multiproc_enable || (frame_bit9_in && mif.hit);
            end
         endcase
         // refused frames still leave a trace in the status register
         drop = !accept;
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.t1_ovf  = 1'b0;
      s_d.t2_ovf  = 1'b0;
      s_d.sh_tick = 1'b0;

      if (s_q.sh_pre == 4'(`UAMBS_DIV_SHIFT - 1)) begin
         s_d.sh_pre  = '0;
         s_d.sh_tick = 1'b1;
      end else begin
         s_d.sh_pre = s_q.sh_pre + 4'h1;
      end

      // timer1 8-bit auto-reload, osc/12 prescale
      // count starts at zero after reset, so the first overflow comes late
      if (s_q.ctrl[`UAMBS_CTRL_T1RUN_BIT]) begin
         if (s_q.t1_pre == 4'(`UAMBS_DIV_T1PRE - 1)) begin
            s_d.t1_pre = '0;
            if (s_q.t1_count == 8'hff) begin
               s_d.t1_count = s_q.timer_one_reload_byte;
               s_d.t1_ovf   = 1'b1;
            end else begin
               s_d.t1_count = s_q.t1_count + 8'h01;
            end
         end else begin
            s_d.t1_pre = s_q.t1_pre + 4'h1;
         end
      end

      if (s_q.ctrl[`UAMBS_CTRL_T2RUN_BIT]) begin
         s_d.t2_pre = ~s_q.t2_pre;
         if (s_q.t2_pre) begin
            if (s_q.t2_count == 16'hffff) begin
               s_d.t2_count = s_q.t2_reload;
               s_d.t2_ovf   = 1'b1;
            end else begin
               s_d.t2_count = s_q.t2_count + 16'h0001;
            end
         end
      end

      if (accept) begin
         s_d.rx_data = frame_data_in;
      end

      // apb writes take effect in the access phase
      if (wr_en) begin
         if (paddr == `UAMBS_OFF_CTRL) begin
            s_d.ctrl = pwdata[7:0];
         end else if (paddr == `UAMBS_OFF_ADDR) begin
            s_d.own_address = pwdata[7:0];
         end else if (paddr == `UAMBS_OFF_MASK) begin
            s_d.address_mask = pwdata[7:0];
         end else if (paddr == `UAMBS_OFF_IRQ_MASK) begin
            s_d.irq_mask = pwdata[`UAMBS_ST_W-1:0];
         end else if (paddr == `UAMBS_OFF_T1_RELOAD) begin
            s_d.timer_one_reload_byte = pwdata[7:0];
         end else if (paddr == `UAMBS_OFF_T2_RELOAD) begin
            s_d.t2_reload = pwdata[15:0];
            // preset the count too, else the first rollover is 64k states away
            s_d.t2_count  = pwdata[15:0];
         end else if (paddr == `UAMBS_OFF_IER) begin
            s_d.serial_irq_enable = pwdata[0];
         end
      end

      // read data is captured in the setup phase so it stands during access
      s_d.rdata = '0;
      if (rd_en) begin
         if (paddr == `UAMBS_OFF_CTRL) begin
            s_d.rdata = {24'h000000, s_q.ctrl};
         end else if (paddr == `UAMBS_OFF_ADDR) begin
            s_d.rdata = {24'h000000, s_q.own_address};
         end else if (paddr == `UAMBS_OFF_MASK) begin
            s_d.rdata = {24'h000000, s_q.address_mask};
         end else if (paddr == `UAMBS_OFF_STAT) begin
            s_d.rdata = {30'h00000000, s_q.stat};
         end else if (paddr == `UAMBS_OFF_IRQ_MASK) begin
            s_d.rdata = {30'h00000000, s_q.irq_mask};
         end else if (paddr == `UAMBS_OFF_T1_RELOAD) begin
            s_d.rdata = {24'h000000, s_q.timer_one_reload_byte};
         end else if (paddr == `UAMBS_OFF_T2_RELOAD) begin
            s_d.rdata = {16'h0000, s_q.t2_reload};
         end else if (paddr == `UAMBS_OFF_RX_DATA) begin
            s_d.rdata = {24'h000000, s_q.rx_data};
         end else if (paddr == `UAMBS_OFF_IER) begin
            s_d.rdata = {31'h00000000, s_q.serial_irq_enable};
         end
      end

      // status clears on the access phase of its read; a new event wins
      if (psel && penable && !pwrite && paddr == `UAMBS_OFF_STAT) begin
         s_d.stat = '0;
      end
      if (accept) begin
         s_d.stat[`UAMBS_ST_RX_DONE] = 1'b1;
      end
      if (drop) begin
         s_d.stat[`UAMBS_ST_DROP] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
         s_q.ctrl <= `UAMBS_RST_CTRL;
         s_q.own_address  <= `UAMBS_RST_ADDR;
         s_q.address_mask <= `UAMBS_RST_MASK;
      end else begin
         s_q <= s_d;
      end
   end

   // irq gated by enable
   // level output: stays high until software reads the status register
   assign irq_out = s_q.serial_irq_enable && |(s_q.stat & s_q.irq_mask);

   uambs_tick_div #(.DIV(`UAMBS_DIV_T1)) u_t1_rx (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .tick_in    (s_q.t1_ovf),
      .halve_in   (baud_doubler),
      .clear_in   (1'b0),
      .tick_out   (t1_div_tick)
   );

   // timer2 overflow over 16, no doubler
   uambs_tick_div #(.DIV(`UAMBS_DIV_T2)) u_t2 (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .tick_in    (s_q.t2_ovf),
      .halve_in   (1'b0),
      .clear_in   (1'b0),
      .tick_out   (t2_div_rx)
   );

   // fixed rate osc/64, doubler halves count
   uambs_tick_div #(.DIV(`UAMBS_DIV_FIX)) u_fix (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .tick_in    (1'b1),
      .halve_in   (baud_doubler),
      .clear_in   (1'b0),
      .tick_out   (fix_tick)
   );

   // own tx dividers
   // separate counters so a tx rate change never shifts the rx bit phase
   uambs_tick_div #(.DIV(`UAMBS_DIV_T1)) u_t1_tx (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .tick_in    (s_q.t1_ovf),
      .halve_in   (baud_doubler),
      .clear_in   (1'b0),
      .tick_out   (t1_div_tx)
   );

   uambs_tick_div #(.DIV(`UAMBS_DIV_T2)) u_t2_tx (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .tick_in    (s_q.t2_ovf),
      .halve_in   (1'b0),
      .clear_in   (1'b0),
      .tick_out   (t2_div_tx)
   );

   always_comb begin
      case (mode)
         uambs_pkg::UAMBS_MODE_SHIFT: begin
            rx_baud_tick_out = s_q.sh_tick;
            tx_baud_tick_out = s_q.sh_tick;
         end
         uambs_pkg::UAMBS_MODE_FIX9: begin
            rx_baud_tick_out = fix_tick;
            tx_baud_tick_out = fix_tick;
         end
         default: begin
            rx_baud_tick_out = t2_rx_sel ? t2_div_rx : t1_div_tick;
            tx_baud_tick_out = t2_tx_sel ? t2_div_tx : t1_div_tx;
         end
      endcase
   end
endmodule
`default_nettype wire

// *** uambs_master_model.sv ***
`default_nettype none
package uambs_vpkg;
   function automatic logic acc(logic [7:0] c, logic [7:0] o, logic [7:0] m,
                                logic [7:0] d, logic b9, logic s);
      logic h;
      h = (((d ^ o) & m) == 8'h00) || ((~d & (o | m)) == 8'h00);
      if (c[1:0] == 2'b00 || !c[2]) return 1'b1;
      return (c[1:0] == 2'b01) ? (s & h) : (b9 & h);
   endfunction
   function automatic int per(logic [7:0] c, logic [7:0] r, logic t2);
      if (c[1:0] == 2'b00) return 12;
      if (c[1:0] == 2'b10) return c[3] ? 32 : 64;
      if (t2 || !c[6]) return 0;
      return (c[3] ? 192 : 384) * (256 - int'(r));
   endfunction
   // timer2: one count per two clocks, sixteen overflows per tick
   function automatic int per2(logic [15:0] r);
      return 32 * (65536 - int'(r));
   endfunction
endpackage

module uambs_master_model (
   input  wire logic  sys_clk_in,
   output logic       frm_vld_out,
   output logic [7:0] frm_dat_out,
   output logic       frm_b9_out,
   output logic       frm_stp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {frm_vld_out, frm_dat_out, frm_b9_out, frm_stp_out} = 11'h000;
   // idle lines show the inverse of the last frame so stale data never looks fresh
   task automatic send(input logic [7:0] d, input logic b9, input logic s, input int gap);
      repeat (gap) @(posedge sys_clk_in);
      {frm_vld_out, frm_dat_out, frm_b9_out, frm_stp_out} <= {1'b1, d, b9, s};
      @(posedge sys_clk_in);
      {frm_vld_out, frm_dat_out, frm_b9_out, frm_stp_out} <= {1'b0, ~d, ~b9, ~s};
   endtask
endmodule
`default_nettype wire

// *** uambs_top_asserts.sv ***
`default_nettype none
module uambs_top_asserts (
   input wire logic        sys_clk_in,
   input wire logic        rst_b_in,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        frame_valid_in,
   input wire logic [7:0]  frame_data_in,
   input wire logic        frame_bit9_in,
   input wire logic        frame_stop_ok_in,
   input wire logic        rx_baud_tick_out,
   input wire logic        tx_baud_tick_out,
   input wire logic        irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  rf_q [9];
   logic [11:0] rg_q, tg_q;
   logic        rs_q, ts_q, wr, cw, hit;
   int          rp, tp;
   assign wr = psel && penable && pwrite && pready && paddr <= 12'h020 && paddr[1:0] == 2'b00;
   // first tick after a rate write may be short, so gaps count from the second
   assign cw = wr && paddr[5:2] inside {4'h0, 4'h5, 4'h6};
   assign hit = uambs_vpkg::acc(rf_q[0], rf_q[1], rf_q[2], frame_data_in, frame_bit9_in,
                                frame_stop_ok_in);
   assign rp = uambs_vpkg::per(rf_q[0], rf_q[5], rf_q[0][4]);
   assign tp = uambs_vpkg::per(rf_q[0], rf_q[5], rf_q[0][5]);
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int k = 0; k < 9; k++) rf_q[k] <= 8'h00;
         {rg_q, tg_q, rs_q, ts_q} <= 26'h0;
      end else begin
         if (wr) rf_q[paddr[5:2]] <= pwdata[7:0];
         rg_q <= rx_baud_tick_out ? 12'h000 : rg_q + 12'h001;
         tg_q <= tx_baud_tick_out ? 12'h000 : tg_q + 12'h001;
         rs_q <= !cw && (rs_q || rx_baud_tick_out);
         ts_q <= !cw && (ts_q || tx_baud_tick_out);
      end
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_frm;
      frame_valid_in && !wr && rf_q[8][0];
   endsequence
   property p_acc;
      s_frm ##0 (rf_q[4][1:0] == 2'b01 && hit) |=> irq_out;
   endproperty
   a_acc: assert property (p_acc) else $error("accepted frame gave no irq");
   property p_rej;
      s_frm ##0 (rf_q[4][1:0] == 2'b01 && !hit && !irq_out) |=> !irq_out;
   endproperty
   a_rej: assert property (p_rej) else $error("refused frame gave irq");
   property p_drop;
      s_frm ##0 (rf_q[4][1:0] == 2'b10 && !hit) |=> irq_out;
   endproperty
   a_drop: assert property (p_drop) else $error("dropped frame not flagged");
   property p_shf;
      s_frm ##0 (rf_q[0][1:0] == 2'b00 && rf_q[4][1:0] == 2'b01) |=> irq_out;
   endproperty
   a_shf: assert property (p_shf) else $error("shift mode frame filtered");
   property p_ien;
      !rf_q[8][0] |-> !irq_out;
   endproperty
   a_ien: assert property (p_ien) else $error("irq while disabled");
   property p_clr;
      psel && penable && !pwrite && paddr == 12'h00c && !frame_valid_in |=> !irq_out;
   endproperty
   a_clr: assert property (p_clr) else $error("irq after status read");
   property p_rtk;
      rx_baud_tick_out && rs_q && rp != 0 |-> rg_q == 12'(rp - 1);
   endproperty
   a_rtk: assert property (p_rtk) else $error("rx tick gap wrong");
   property p_ttk;
      tx_baud_tick_out && ts_q && tp != 0 |-> tg_q == 12'(tp - 1);
   endproperty
   a_ttk: assert property (p_ttk) else $error("tx tick gap wrong");
endmodule
bind uambs_top uambs_top_asserts i_chk (.*);
`default_nettype wire

// *** uart_addr_match_baud_select_tb_top.sv ***
`default_nettype none
module uart_addr_match_baud_select_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er, frame_valid_in, frame_bit9_in, frame_stop_ok_in;
   logic        rx_baud_tick_out, tx_baud_tick_out, irq_out, ie, a, b, s;
   logic [7:0]  frame_data_in, c, o, m, d;
   logic [1:0]  im;
   logic [7:0]  lb = 8'h00;
   logic [7:0]  bc [6] = '{8'h40, 8'h42, 8'h4a, 8'h41, 8'h4b, 8'h61};
   logic [7:0]  br [6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hfd, 8'hfe};
   int          mismatches = 0, n_tests = 0, cyc = 0, seed = 32'hacc7, g;
   uambs_top i_dut (.sys_clk_in, .rst_b_in, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .frame_valid_in, .frame_data_in, .frame_bit9_in,
      .frame_stop_ok_in, .rx_baud_tick_out, .tx_baud_tick_out, .irq_out);
   uambs_master_model i_mst (.sys_clk_in, .frm_vld_out(frame_valid_in),
      .frm_dat_out(frame_data_in), .frm_b9_out(frame_bit9_in), .frm_stp_out(frame_stop_ok_in));
   always #12.5 sys_clk_in = ~sys_clk_in;
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] sn, input logic [31:0] ex);
      n_tests++;
      if (sn !== ex) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, ex, sn);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, wd};
      @(posedge sys_clk_in);
      penable <= 1'b1;
      g = 0;
      do begin
         @(posedge sys_clk_in);
         g++;
      end while (pready !== 1'b1 && g < 20);
      if (g == 20) mismatches++;
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge sys_clk_in);
   endtask
   // gap between the second and third tick, so a cut-short first period is skipped
   task automatic meas(input logic t, input int e);
      int n = 0;
      int k = 0;
      while (k < 3 && n < 5000) begin
         @(posedge sys_clk_in);
         n++;
         if ((t ? tx_baud_tick_out : rx_baud_tick_out) === 1'b1) begin
            k++;
            if (k < 3) n = 0;
         end
      end
      chk(t ? "tx_gap" : "rx_gap", 32'(n), 32'(e));
   endtask
   initial begin
      repeat (20) @(posedge sys_clk_in);
      rst_b_in <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk("addr_rst", rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk("mask_rst", rd, 32'h0);
      apb(1'b0, 12'h024, 32'h0);
      chk("unmapped_data", rd, 32'h0);
      chk("unmapped_err", {31'h0, er}, 32'h1);
      for (int i = 0; i < 64; i++) begin
         c = 8'($random(seed)) & 8'h0f;
         o = 8'($random(seed));
         m = 8'($random(seed));
         d = 8'($random(seed));
         if (i % 3 == 1) d = (o & m) | (d & ~m);
         if (i % 3 == 2) d = d | o | m;
         {b, s} = 2'($random(seed));
         ie = i % 5 != 4;
         im = i[0] ? 2'b10 : 2'b01;
         apb(1'b1, 12'h000, {24'h0, c});
         apb(1'b1, 12'h004, {24'h0, o});
         apb(1'b1, 12'h008, {24'h0, m});
         apb(1'b1, 12'h010, {30'h0, im});
         apb(1'b1, 12'h020, {31'h0, ie});
         apb(1'b0, 12'h008, 32'h0);
         chk("mask", rd, {24'h0, m});
         a = uambs_vpkg::acc(c, o, m, d, b, s);
         i_mst.send(d, b, s, i % 4);
         @(posedge sys_clk_in);
         chk("irq", {31'h0, irq_out}, {31'h0, ie & (im[0] ? a : !a)});
         apb(1'b0, 12'h00c, 32'h0);
         chk("stat", rd, {30'h0, !a, a});
         apb(1'b0, 12'h00c, 32'h0);
         chk("stat_clr", rd, 32'h0);
         if (a) lb = d;
         apb(1'b0, 12'h01c, 32'h0);
         chk("rx_data", rd, {24'h0, lb});
      end
      // second reset in mid-run: address registers must clear again
      apb(1'b1, 12'h004, 32'h0000005a);
      apb(1'b1, 12'h008, 32'h000000ff);
      rst_b_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      rst_b_in <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk("addr_rst2", rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk("mask_rst2", rd, 32'h0);
      for (int j = 0; j < 6; j++) begin
         apb(1'b1, 12'h014, {24'h0, br[j]});
         apb(1'b1, 12'h000, {24'h0, bc[j]});
         meas(1'b0, uambs_vpkg::per(bc[j], br[j], bc[j][4]));
         if (!bc[j][5]) meas(1'b1, uambs_vpkg::per(bc[j], br[j], 1'b0));
      end
      // timer2 as rate source: receiver first, then transmitter
      apb(1'b1, 12'h018, 32'h0000fffe);
      apb(1'b1, 12'h000, 32'h000000d1);
      meas(1'b0, uambs_vpkg::per2(16'hfffe));
      meas(1'b1, uambs_vpkg::per(8'hd1, 8'hfe, 1'b0));
      apb(1'b1, 12'h018, 32'h0000fffc);
      apb(1'b1, 12'h000, 32'h000000a1);
      meas(1'b1, uambs_vpkg::per2(16'hfffc));
      give_verdict();
   end
endmodule
`default_nettype wire
